// ===== inc/dsr_link_if.sv
// link between the memory controller end and the burst sram end
`timescale 1ns/10ps
interface dsr_link_if #(
    parameter int DATA_W = 36,
    parameter int ADDR_W = 21,
    parameter int LANES = 4
);
    // k_phase high: positive-edge slot; low: complementary-edge slot
    logic k_phase;
    logic load_strobe_n;
    logic rw_sel;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq;
    logic [LANES-1:0] byte_lane_mask_n;

    modport ctrl
    (
        output k_phase,
        output load_strobe_n,
        output rw_sel,
        output addr,
        output dq,
        output byte_lane_mask_n
    );

    modport sram
    (
        input k_phase,
        input load_strobe_n,
        input rw_sel,
        input addr,
        input dq,
        input byte_lane_mask_n
    );
endinterface : dsr_link_if

// ===== inc/dsr_params.svh
// timing, width and reset constants for the burst sram link
`ifndef DSR_PARAMS_SVH
`define DSR_PARAMS_SVH

`define DSR_DATA_W 36
`define DSR_ADDR_W_NARROW 22
`define DSR_ADDR_W_X18 22
`define DSR_ADDR_W_X36 21
`define DSR_LANE_W_NIBBLE 4
`define DSR_LANE_W_BYTE 9
`define DSR_BURST_LEN 2
`define DSR_FIFO_DEPTH 8
`define DSR_RW_READ 1'b1
`define DSR_RW_WRITE 1'b0
`define DSR_K_RESET 1'b0
`define DSR_LOAD_IDLE 1'b1

`endif

// ===== inc/dsr_pkg.sv
// types and width helpers shared by both ends of the burst sram link
`include "dsr_params.svh"
package dsr_pkg;

    typedef enum logic
    {
        dsr_half_first = 1'b0,
        dsr_half_second = 1'b1
    } dsr_half_t;

    function automatic int dsr_addr_w(input int data_w);
        if (data_w <= 9)
            return `DSR_ADDR_W_NARROW;
        else if (data_w == 18)
            return `DSR_ADDR_W_X18;
        else
            return `DSR_ADDR_W_X36;
    endfunction : dsr_addr_w

    function automatic int dsr_lanes(input int data_w);
        if (data_w == 8)
            return data_w / `DSR_LANE_W_NIBBLE;
        else
            return data_w / `DSR_LANE_W_BYTE;
    endfunction : dsr_lanes

endpackage : dsr_pkg

// ===== logic/dsr_ctrl_end.sv
// memory controller end: queues burst commands and drives them onto the link
`timescale 1ns/10ps
`include "dsr_params.svh"
module dsr_ctrl_end
    import dsr_pkg::*;
#(
    parameter int DATA_W = `DSR_DATA_W,
    parameter int ADDR_W = dsr_addr_w(DATA_W),
    parameter int LANES = dsr_lanes(DATA_W),
    parameter int FIFO_DEPTH = `DSR_FIFO_DEPTH
)
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    dsr_link_if.ctrl link,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_rw,
    input wire logic [ADDR_W-1:0] cmd_addr,
    input wire logic [DATA_W-1:0] cmd_word0,
    input wire logic [DATA_W-1:0] cmd_word1,
    input wire logic [LANES-1:0] cmd_mask0_n,
    input wire logic [LANES-1:0] cmd_mask1_n
);
    localparam int FW = 1 + ADDR_W + 2 * DATA_W + 2 * LANES;

    generate
        if (LANES != dsr_lanes(DATA_W) || ADDR_W > dsr_addr_w(DATA_W))
        begin : g_bad_cfg
            $error("dsr_ctrl_end: lanes or address width do not fit the data width");
        end
    endgenerate

    typedef struct packed {
        logic k_phase;
        dsr_half_t half;
        logic load_strobe_n;
        logic rw_sel;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq;
        logic [LANES-1:0] mask_n;
        logic [DATA_W-1:0] word1;
        logic [LANES-1:0] mask1_n;
    } dsr_ctrl_state_t;

    dsr_ctrl_state_t s;
    dsr_ctrl_state_t next_s;
    logic q_valid;
    logic pop;
    logic [FW-1:0] q_data;
    logic q_rw;
    logic [ADDR_W-1:0] q_addr;
    logic [DATA_W-1:0] q_w0;
    logic [DATA_W-1:0] q_w1;
    logic [LANES-1:0] q_m0;
    logic [LANES-1:0] q_m1;

    ////////////////////////////////////////////////////////////////////////////
    // the link drains at most one burst per two cycles, so the fifo really fills
    dsr_fifo #(
        .WIDTH(FW),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .ce(ce),
        .in_valid(cmd_valid),
        .in_ready(cmd_ready),
        .in_data({cmd_rw, cmd_addr, cmd_word0, cmd_word1, cmd_mask0_n, cmd_mask1_n}),
        .out_valid(q_valid),
        .out_ready(pop),
        .out_data(q_data)
    );

    assign {q_rw, q_addr, q_w0, q_w1, q_m0, q_m1} = q_data;
    // a new access may start only in the slot that opens a positive edge
    assign pop = !s.k_phase && (s.half == dsr_half_first);

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_s = s;
        next_s.k_phase = !s.k_phase;
        next_s.load_strobe_n = `DSR_LOAD_IDLE;
        if (pop && q_valid)
        begin
            next_s.load_strobe_n = 1'b0;
            next_s.rw_sel = q_rw;
            next_s.addr = q_addr;
            next_s.dq = q_w0;
            // reads carry no mask; writes pair each mask with its word
            next_s.mask_n = (q_rw == `DSR_RW_READ) ? '1 : q_m0;
            next_s.word1 = q_w1;
            next_s.mask1_n = (q_rw == `DSR_RW_READ) ? '1 : q_m1;
            next_s.half = dsr_half_second;
        end
        else if (s.half == dsr_half_second)
        begin
            next_s.dq = s.word1;
            next_s.mask_n = s.mask1_n;
            next_s.half = dsr_half_first;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            s <= '0;
            s.k_phase <= `DSR_K_RESET;
            s.load_strobe_n <= `DSR_LOAD_IDLE;
            s.mask_n <= '1;
            s.mask1_n <= '1;
        end
        else if (ce)
            s <= next_s;
    end

    assign link.k_phase = s.k_phase;
    assign link.load_strobe_n = s.load_strobe_n;
    assign link.rw_sel = s.rw_sel;
    assign link.addr = s.addr;
    assign link.dq = s.dq;
    assign link.byte_lane_mask_n = s.mask_n;
endmodule : dsr_ctrl_end

// ===== logic/dsr_fifo.sv
// command fifo with valid/ready on both sides
`timescale 1ns/10ps
`include "dsr_params.svh"
module dsr_fifo
    import dsr_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = `DSR_FIFO_DEPTH
)
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
        begin : g_bad_cfg
            $error("dsr_fifo: depth must be a power of two of at least 2");
        end
    endgenerate

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0] count;
    } dsr_fifo_state_t;

    dsr_fifo_state_t s;
    dsr_fifo_state_t next_s;
    logic push;
    logic pop;

    ////////////////////////////////////////////////////////////////////////////
    assign in_ready = (s.count != DEPTH[PW:0]);
    assign out_valid = (s.count != '0);
    assign out_data = s.mem[s.rp];
    assign push = ce & in_valid & in_ready;
    assign pop = ce & out_valid & out_ready;

    always_comb
    begin
        next_s = s;
        if (push)
        begin
            next_s.mem[s.wp] = in_data;
            next_s.wp = s.wp + 1'b1;
        end
        if (pop)
            next_s.rp = s.rp + 1'b1;
        case ({push, pop})
            2'b10: next_s.count = s.count + 1'b1;
            2'b01: next_s.count = s.count - 1'b1;
            default: next_s.count = s.count;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            s <= '0;
        else
            s <= next_s;
    end
endmodule : dsr_fifo

// ===== logic/dsr_sram_end.sv
// burst sram end: command, address and write-mask input stage with its array
`timescale 1ns/10ps
`include "dsr_params.svh"
module dsr_sram_end
    import dsr_pkg::*;
#(
    parameter int DATA_W = `DSR_DATA_W,
    parameter int ADDR_W = dsr_addr_w(DATA_W),
    parameter int LANES = dsr_lanes(DATA_W)
)
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    dsr_link_if.sram link,
    output logic rd_valid,
    output logic [DATA_W-1:0] rd_data,
    output logic wr_done,
    output logic [DATA_W-1:0] wr_data,
    output logic busy
);
    localparam bit NARROW = (DATA_W <= 9);
    localparam int COL_W = NARROW ? ADDR_W + 1 : ADDR_W;
    localparam int LANE_W = DATA_W / LANES;
    localparam int WORDS = 1 << COL_W;

    ////////////////////////////////////////////////////////////////////////////
    generate
        if (!(DATA_W == 8 || DATA_W == 9 || DATA_W == 18 || DATA_W == 36))
        begin : g_bad_width
            $error("dsr_sram_end: data width must be 8, 9, 18 or 36");
        end
        if (LANES != dsr_lanes(DATA_W) || ADDR_W < 2 || ADDR_W > dsr_addr_w(DATA_W))
        begin : g_bad_addr
            $error("dsr_sram_end: lanes or address width do not fit the data width");
        end
        if (LANE_W != `DSR_LANE_W_NIBBLE && LANE_W != `DSR_LANE_W_BYTE)
        begin : g_bad_lane
            $error("dsr_sram_end: lanes must be four or nine bits wide");
        end
        if (`DSR_BURST_LEN != 2)
        begin : g_bad_burst
            // the burst counter is one bit wide, so it serves two words only
            $error("dsr_sram_end: the burst counter serves exactly two words");
        end
        if (COL_W > 30)
        begin : g_bad_depth
            $error("dsr_sram_end: address too wide for the array depth count");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        dsr_half_t half;
        // direction and column kept from the load for the second word
        logic rw;
        logic [COL_W-1:0] col;
        logic rd_valid;
        logic [DATA_W-1:0] rd_data;
        logic wr_done;
        logic [DATA_W-1:0] wr_data;
    } dsr_sram_state_t;

    dsr_sram_state_t s;
    dsr_sram_state_t next_s;
    // two columns per burst address; the array has no reset, contents start unknown
    logic [DATA_W-1:0] mem [0:WORDS-1];

    logic take;
    logic second;
    logic acc;
    logic acc_write;
    logic burst_seed_bit;
    logic [COL_W-1:0] col_start;
    logic [COL_W-1:0] col_next;
    logic [COL_W-1:0] acc_col;
    logic [DATA_W-1:0] old_word;
    logic [DATA_W-1:0] merged;

    ////////////////////////////////////////////////////////////////////////////
    // link comes from logic on clk_sys, so it is sampled directly
    // a load is seen only in the positive-edge slot; address is don't-care else
    // a load is refused while the second word of a burst is still due
    assign take = ce && link.k_phase && !link.load_strobe_n
        && (s.half == dsr_half_first);
    // the complementary-edge slot of a loaded burst carries its second word
    assign second = ce && !link.k_phase && (s.half == dsr_half_second);
    assign acc = take || second;

    generate
        if (NARROW)
        begin : g_narrow
            // the internal low column bit always starts at zero
            assign burst_seed_bit = 1'b0;
            assign col_start = {link.addr, burst_seed_bit};
        end
        else
        begin : g_wide
            // lowest external bit loads the one-bit burst counter
            assign burst_seed_bit = link.addr[0];
            assign col_start = {link.addr[ADDR_W-1:1], burst_seed_bit};
        end
    endgenerate

    // linear one-bit counter: increment wraps within the pair
    assign col_next = {col_start[COL_W-1:1], ~col_start[0]};
    // the load slot uses the pins; the second slot uses what the load kept
    always_comb
    begin
        acc_col = s.col;
        acc_write = (s.rw == `DSR_RW_WRITE);
        if (take)
        begin
            acc_col = col_start;
            acc_write = (link.rw_sel == `DSR_RW_WRITE);
        end
    end
    assign old_word = mem[acc_col];

    ////////////////////////////////////////////////////////////////////////////
    // each lane mask is taken in the same slot as the word it qualifies
    genvar lane;
    generate
        for (lane = 0; lane < LANES; lane++)
        begin : g_lane
            // lane i covers bits [i*LANE_W +: LANE_W]: 3:0/7:4 or 8:0..35:27
            assign merged[lane*LANE_W +: LANE_W] = link.byte_lane_mask_n[lane]
                ? old_word[lane*LANE_W +: LANE_W]
                : link.dq[lane*LANE_W +: LANE_W];
        end
    endgenerate

    // a fully masked word still rewrites its old value, which changes nothing
    always_ff @(posedge clk_sys)
    begin
        if (acc && acc_write)
            mem[acc_col] <= merged;
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_s = s;
        next_s.rd_valid = 1'b0;
        next_s.wr_done = 1'b0;
        case (s.half)
            dsr_half_first:
            begin
                if (take)
                begin
                    next_s.half = dsr_half_second;
                    next_s.rw = link.rw_sel;
                    next_s.col = col_next;
                end
            end
            dsr_half_second:
            begin
                // the partner word lands in the complementary slot
                if (second)
                    next_s.half = dsr_half_first;
            end
            default:
                next_s.half = dsr_half_first;
        endcase
        if (acc && !acc_write)
        begin
            next_s.rd_valid = 1'b1;
            next_s.rd_data = old_word;
        end
        if (acc && acc_write)
        begin
            next_s.wr_done = 1'b1;
            next_s.wr_data = merged;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            s <= '0;
        else if (ce)
            s <= next_s;
    end

    ////////////////////////////////////////////////////////////////////////////
    assign rd_valid = s.rd_valid;
    assign rd_data = s.rd_data;
    assign wr_done = s.wr_done;
    assign wr_data = s.wr_data;
    assign busy = (s.half == dsr_half_second);
endmodule : dsr_sram_end

// ===== verif/dsr_link_asserts.sv
// link checker: slot timing and read masks between the two ends
`timescale 1ns/10ps
module dsr_link_asserts
#(
    parameter int DATA_W = 36,
    parameter int ADDR_W = 4,
    parameter int LANES = 4
)
(
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    input wire logic k_phase,
    input wire logic load_strobe_n,
    input wire logic rw_sel,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] dq,
    input wire logic [LANES-1:0] byte_lane_mask_n
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////
    property p_slot_toggle;
        $past(nrst) && $past(ce) |-> k_phase != $past(k_phase);
    endproperty
    property p_freeze;
        $past(nrst) && !$past(ce) |-> $stable(k_phase) && $stable(load_strobe_n);
    endproperty
    property p_load_in_pos;
        !load_strobe_n |-> k_phase;
    endproperty
    property p_load_fall;
        $fell(load_strobe_n) |-> !$past(k_phase);
    endproperty
    property p_load_one;
        !load_strobe_n |=> load_strobe_n;
    endproperty
    property p_second_slot;
        !load_strobe_n |=> !k_phase;
    endproperty
    property p_next_slot;
        !load_strobe_n |-> ##2 k_phase;
    endproperty
    property p_rd_mask0;
        !load_strobe_n && rw_sel |-> &byte_lane_mask_n;
    endproperty
    property p_rd_mask1;
        !load_strobe_n && rw_sel |=> &byte_lane_mask_n;
    endproperty
    a_slot_toggle: assert property (p_slot_toggle)
        else $error("slot marker did not alternate");
    a_freeze: assert property (p_freeze)
        else $error("link moved while clock enable was low");
    a_load_in_pos: assert property (p_load_in_pos)
        else $error("load outside positive slot");
    a_load_fall: assert property (p_load_fall)
        else $error("load fell after positive slot");
    a_load_one: assert property (p_load_one)
        else $error("load held past one cycle");
    a_second_slot: assert property (p_second_slot)
        else $error("second word not in complementary slot");
    a_next_slot: assert property (p_next_slot)
        else $error("burst longer than two slots");
    a_rd_mask0: assert property (p_rd_mask0)
        else $error("read carries write mask on word 0");
    a_rd_mask1: assert property (p_rd_mask1)
        else $error("read carries write mask on word 1");
    ////////////////////////////////////////
    c_write: cover property (!load_strobe_n && !rw_sel && addr[0]);
    c_read: cover property (!load_strobe_n && rw_sel && dq == '0);
    c_masked: cover property (!load_strobe_n && !rw_sel && !(&byte_lane_mask_n));
    c_back: cover property (!load_strobe_n ##2 !load_strobe_n);
endmodule : dsr_link_asserts

// ===== verif/tb_top.sv
// bench: controller end and sram end joined, plus a hand-driven sram end
`timescale 1ns/10ps
module tb_top;
    localparam int DW = 36;
    localparam int AW = 4;
    localparam int LN = 4;
    logic clk_sys, nrst, ce, cmd_valid, cmd_ready, cmd_rw, rd_valid, wr_done, wr_done2, busy2;
    logic [3:0] cmd_addr, cmd_mask0_n, cmd_mask1_n;
    logic [35:0] cmd_word0, cmd_word1, rd_data, wr_data2;
    logic [35:0] ref_mem [16];
    logic [35:0] rd_q [$];
    logic [35:0] wr2_q [$];
    int wr_cnt, stalls, n_errors, checks_done;
    dsr_link_if #(.DATA_W(DW), .ADDR_W(AW), .LANES(LN)) link ();
    dsr_link_if #(.DATA_W(DW), .ADDR_W(AW), .LANES(LN)) link2 ();
    dsr_ctrl_end #(.DATA_W(DW), .ADDR_W(AW), .LANES(LN)) dsr_ctrl_end_inst
    (
        .clk_sys(clk_sys), .nrst(nrst), .ce(ce), .link(link), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_rw(cmd_rw), .cmd_addr(cmd_addr), .cmd_word0(cmd_word0),
        .cmd_word1(cmd_word1), .cmd_mask0_n(cmd_mask0_n), .cmd_mask1_n(cmd_mask1_n)
    );
    dsr_sram_end #(.DATA_W(DW), .ADDR_W(AW), .LANES(LN)) dsr_sram_end_inst
    (
        .clk_sys(clk_sys), .nrst(nrst), .ce(ce), .link(link), .rd_valid(rd_valid),
        .rd_data(rd_data), .wr_done(wr_done), .wr_data(), .busy()
    );
    // second sram end faces the bench, which breaks the slot rules on purpose
    if (1)
    begin : g_rogue
        dsr_sram_end #(.DATA_W(DW), .ADDR_W(AW), .LANES(LN)) dsr_sram_end_inst
        (
            .clk_sys(clk_sys), .nrst(nrst), .ce(ce), .link(link2), .rd_valid(),
            .rd_data(), .wr_done(wr_done2), .wr_data(wr_data2), .busy(busy2)
        );
    end
    dsr_link_asserts #(.DATA_W(DW), .ADDR_W(AW), .LANES(LN)) dsr_link_asserts_inst
    (
        .clk_sys(clk_sys), .nrst(nrst), .ce(ce), .k_phase(link.k_phase),
        .load_strobe_n(link.load_strobe_n), .rw_sel(link.rw_sel), .addr(link.addr),
        .dq(link.dq), .byte_lane_mask_n(link.byte_lane_mask_n)
    );
    ////////////////////////////////////////
    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys or negedge nrst)
        if (!nrst)
            link2.k_phase <= 1'b0;
        else
            link2.k_phase <= ~link2.k_phase;
    always @(posedge clk_sys)
    begin
        if (rd_valid === 1'b1)
            rd_q.push_back(rd_data);
        if (wr_done === 1'b1)
            wr_cnt++;
        if (wr_done2 === 1'b1)
            wr2_q.push_back(wr_data2);
    end
    ////////////////////////////////////////
    task end_of_test;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_of_test
    task chk(input string what, input logic [35:0] exp, input logic [35:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task timeout_hit;
        chk("wait_bound", 36'h1, 36'h0);
        end_of_test();
    endtask : timeout_hit
    function automatic logic [35:0] merge(input logic [35:0] old, input logic [35:0] nw,
                                          input logic [3:0] m_n);
        merge = old;
        for (int i = 0; i < 4; i++)
            if (!m_n[i])
                merge[9*i +: 9] = nw[9*i +: 9];
    endfunction : merge
    function automatic logic [35:0] pat(input int k, input int h);
        pat = {28'h5a5ac3c, k[6:0], h[0]};
    endfunction : pat
    // caller sits just after an edge; returns at the edge that takes the command
    task send(input logic rw, input logic [3:0] a, input logic [35:0] w0,
              input logic [35:0] w1, input logic [3:0] m0, input logic [3:0] m1);
        int n;
        cmd_valid <= 1'b1;
        cmd_rw <= rw;
        cmd_addr <= a;
        cmd_word0 <= w0;
        cmd_word1 <= w1;
        cmd_mask0_n <= m0;
        cmd_mask1_n <= m1;
        if (!rw)
        begin
            ref_mem[a] = merge(ref_mem[a], w0, m0);
            ref_mem[a ^ 4'h1] = merge(ref_mem[a ^ 4'h1], w1, m1);
        end
        n = 0;
        @(negedge clk_sys);
        while (cmd_ready !== 1'b1 && n < 50)
        begin
            stalls++;
            @(negedge clk_sys);
            n++;
        end
        if (cmd_ready !== 1'b1)
            timeout_hit();
        @(posedge clk_sys);
    endtask : send
    task read_chk(input logic [3:0] a);
        int n;
        rd_q.delete();
        send(1'b1, a, 36'h0, 36'h0, 4'hf, 4'hf);
        cmd_valid <= 1'b0;
        n = 0;
        while (rd_q.size() < 2 && n < 40)
        begin
            @(posedge clk_sys);
            n++;
        end
        if (rd_q.size() < 2)
            timeout_hit();
        chk("rd_col0", ref_mem[a], rd_q[0]);
        chk("rd_col1", ref_mem[a ^ 4'h1], rd_q[1]);
    endtask : read_chk
    ////////////////////////////////////////
    task t_basic;
        int n0;
        n0 = wr_cnt;
        send(1'b0, 4'h5, 36'h123456789, 36'hfedcba987, 4'h0, 4'h0);
        read_chk(4'h5);
        read_chk(4'h4);
        chk("write_pulses", 36'(n0 + 2), 36'(wr_cnt));
    endtask : t_basic
    task t_masks;
        send(1'b0, 4'h8, 36'hfffffffff, 36'h0, 4'h0, 4'h0);
        for (int i = 0; i < 4; i++)
        begin
            send(1'b0, 4'h8, pat(i, 0), pat(i, 1), ~(4'h1 << i), 4'h1 << i);
            read_chk(4'h8);
        end
    endtask : t_masks
    task t_fill;
        int n0;
        int n;
        n0 = wr_cnt;
        stalls = 0;
        for (int k = 0; k < 24; k++)
            send(1'b0, 4'(k), pat(k, 0), pat(k, 1), 4'h0, 4'h0);
        cmd_valid <= 1'b0;
        n = 0;
        while (wr_cnt < n0 + 48 && n < 200)
        begin
            @(posedge clk_sys);
            n++;
        end
        if (wr_cnt < n0 + 48)
            timeout_hit();
        chk("queue_refused", 36'h1, 36'(stalls > 0));
        chk("fill_pulses", 36'(n0 + 48), 36'(wr_cnt));
        for (int a = 0; a < 16; a += 2)
            read_chk(4'(a));
    endtask : t_fill
    // clock enable low must hold both ends and take the offered command only once it returns high
    task t_freeze;
        int n0;
        logic k0;
        n0 = wr_cnt;
        ce <= 1'b0;
        cmd_valid <= 1'b1;
        cmd_rw <= 1'b0;
        cmd_addr <= 4'hc;
        cmd_word0 <= 36'h0a5a5a5a5;
        cmd_word1 <= 36'h05a5a5a5a;
        cmd_mask0_n <= 4'h0;
        cmd_mask1_n <= 4'h0;
        ref_mem[4'hc] = 36'h0a5a5a5a5;
        ref_mem[4'hd] = 36'h05a5a5a5a;
        @(posedge clk_sys);
        k0 = link.k_phase;
        repeat (4) @(posedge clk_sys);
        chk("freeze_phase", 36'(k0), 36'(link.k_phase));
        chk("freeze_load", 36'h1, 36'(link.load_strobe_n));
        chk("freeze_writes", 36'(n0), 36'(wr_cnt));
        ce <= 1'b1;
        @(posedge clk_sys);
        read_chk(4'hc);
        chk("thaw_writes", 36'(n0 + 2), 36'(wr_cnt));
    endtask : t_freeze
    task t_rogue;
        int n0;
        n0 = wr2_q.size();
        @(posedge clk_sys);
        if (link2.k_phase !== 1'b1)
            @(posedge clk_sys);
        link2.load_strobe_n <= 1'b0;
        link2.dq <= 36'h111111111;
        link2.byte_lane_mask_n <= 4'h0;
        @(posedge clk_sys);
        link2.load_strobe_n <= 1'b1;
        @(posedge clk_sys);
        link2.addr <= 4'h9;
        @(posedge clk_sys);
        chk("stray_load", 36'(n0), 36'(wr2_q.size()));
        link2.load_strobe_n <= 1'b0;
        link2.addr <= 4'h2;
        link2.dq <= 36'h2468ace02;
        @(posedge clk_sys);
        link2.load_strobe_n <= 1'b1;
        link2.dq <= 36'h13579bdf1;
        @(negedge clk_sys);
        chk("busy_mid", 36'h1, 36'(busy2));
        @(posedge clk_sys);
        link2.dq <= ~link2.dq;
        repeat (2) @(posedge clk_sys);
        chk("wr2_count", 36'(n0 + 2), 36'(wr2_q.size()));
        chk("wr2_word0", 36'h2468ace02, wr2_q[n0]);
        chk("wr2_word1", 36'h13579bdf1, wr2_q[n0 + 1]);
    endtask : t_rogue
    ////////////////////////////////////////
    initial
    begin
        nrst = 1'b0;
        ce = 1'b1;
        cmd_valid = 1'b0;
        cmd_rw = 1'b0;
        cmd_addr = 4'h0;
        cmd_word0 = 36'h0;
        cmd_word1 = 36'h0;
        cmd_mask0_n = 4'hf;
        cmd_mask1_n = 4'hf;
        link2.load_strobe_n = 1'b1;
        link2.rw_sel = 1'b0;
        link2.addr = 4'h0;
        link2.dq = 36'h0;
        link2.byte_lane_mask_n = 4'hf;
        n_errors = 0;
        checks_done = 0;
        wr_cnt = 0;
        stalls = 0;
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        t_basic();
        t_masks();
        t_fill();
        t_freeze();
        t_rogue();
        end_of_test();
    end
endmodule : tb_top
